// ### rtl/apod_top.sv
`timescale 1ns/1ps
`default_nettype none

module apod_top
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      wr_en,
	input  wire logic [apod_pkg::ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]                wr_data,
	input  wire logic                      nc_mode,
	output var  logic                      standby_req,
	output var  logic                      forced_standby_req,
	output var  logic                      regulator_on,
	output var  logic                      valve_drive_on,
	output var  logic                      port4_dout,
	output var  logic [8*apod_pkg::PD_BYTES-1:0] iolink_pd,
	output var  logic [7:0]                status_code
);
	import apod_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       stby;
		logic       fstby;
		logic       iso_nc;
		logic       iso_no;
		logic       regulator;
		logic       valve;
		logic       dout;
		logic [7:0] status;
	} apod_state_t;

	apod_state_t st_reg;
	apod_state_t st_next;

	logic wr_ctrl;
	logic wr_dout;
	logic nc_supply;
	logic no_supply;
	logic isolated;

	apod_wr_if wr_bus ();

	// ----------------------------------------------------------------
	// write strobe fan-out
	// ----------------------------------------------------------------
	// one strobe feeds the control bytes and every process data byte
	assign wr_bus.wr_en   = wr_en;
	assign wr_bus.wr_addr = wr_addr;
	assign wr_bus.wr_data = wr_data;

	assign wr_ctrl = wr_en && (wr_addr == OFS_CTRL);
	assign wr_dout = wr_en && (wr_addr == OFS_DOUT);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// outputs decode the freshly written bits so a write shows on the write edge itself
	always_comb
	begin
		st_next = st_reg;
		if (wr_ctrl)
		begin
			st_next.stby   = wr_data[BIT_STBY];
			st_next.fstby  = wr_data[BIT_FSTBY];
			st_next.iso_nc = wr_data[BIT_ISO_NC];
			st_next.iso_no = wr_data[BIT_ISO_NO];
			// bits 7..4 are never looked at
		end
		if (wr_dout)
		begin
			st_next.dout = wr_data[BIT_DOUT];
		end

		// only the bit matching the switch is consulted
		if (nc_mode)
		begin
			// nc: low exhausts with both off, high supplies with both on
			st_next.regulator = st_next.iso_nc;
			st_next.valve     = st_next.iso_nc;
		end
		else
		begin
			// no: low supplies valve off, high exhausts valve on
			st_next.regulator = !st_next.iso_no;
			st_next.valve     = st_next.iso_no;
		end

		// forced standby outranks plain standby, then isolation
		if (st_next.fstby)
		begin
			st_next.status = ST_FSTBY;
		end
		else if (st_next.stby)
		begin
			st_next.status = ST_STBY;
		end
		else if (!st_next.regulator)
		begin
			st_next.status = ST_ISOLATE;
		end
		else
		begin
			st_next.status = ST_OPER;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset leaves all requests off; nc image of zero means exhausted
	// status starts as isolated so it never disagrees with the regulator
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_reg <= '{stby: 1'b0, fstby: 1'b0, iso_nc: 1'b0, iso_no: 1'b0,
				regulator: 1'b0, valve: 1'b0, dout: 1'b0, status: ST_ISOLATE};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// process data bytes
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < PD_BYTES; gi++)
		begin : g_pd
			apod_byte_reg
			#(
				.BYTE_OFS (5'(OFS_PD_FIRST + gi))
			)
			u_pd
			(
				.sys_clk (sys_clk),
				.rst     (rst),
				.wr      (wr_bus.dst),
				.q       (iolink_pd[8*gi +: 8])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign standby_req        = st_reg.stby;
	assign forced_standby_req = st_reg.fstby;
	assign regulator_on       = st_reg.regulator;
	assign valve_drive_on     = st_reg.valve;
	assign port4_dout         = st_reg.dout;
	assign status_code        = st_reg.status;

	// helper terms for checks only
	assign nc_supply = st_reg.iso_nc;
	assign no_supply = !st_reg.iso_no;
	assign isolated  = !st_reg.regulator;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	standby_bit_a: assert property (
		wr_ctrl |=> standby_req == $past(wr_data[BIT_STBY]))
		else $error("standby request not taken from bit 0");

	forced_bit_a: assert property (
		wr_ctrl |=> forced_standby_req == $past(wr_data[BIT_FSTBY]))
		else $error("forced standby not taken from bit 1");

	nc_drive_a: assert property (
		(wr_ctrl && nc_mode) |=>
		(regulator_on == $past(wr_data[BIT_ISO_NC])) &&
		(valve_drive_on == $past(wr_data[BIT_ISO_NC])))
		else $error("nc isolation drive wrong");

	nc_ignore_a: assert property (
		(wr_ctrl && !nc_mode && wr_data[BIT_ISO_NO] == st_reg.iso_no
		&& !$past(nc_mode)) |=> $stable(regulator_on) && $stable(valve_drive_on))
		else $error("nc bit acted while switch selects no");

	no_drive_a: assert property (
		(wr_ctrl && !nc_mode) |=>
		(regulator_on == !$past(wr_data[BIT_ISO_NO])) &&
		(valve_drive_on == $past(wr_data[BIT_ISO_NO])))
		else $error("no isolation drive wrong");

	no_ignore_a: assert property (
		(wr_ctrl && nc_mode && wr_data[BIT_ISO_NC] == st_reg.iso_nc
		&& $past(nc_mode)) |=> $stable(valve_drive_on))
		else $error("no bit acted while switch selects nc");

	dout_bit_a: assert property (
		wr_dout |=> port4_dout == $past(wr_data[BIT_DOUT]))
		else $error("port 4 output not taken from bit 6");

	standby_code_a: assert property (
		(standby_req && !forced_standby_req) |-> status_code == ST_STBY)
		else $error("standby status code wrong");

	forced_code_a: assert property (
		(wr_ctrl && wr_data[BIT_FSTBY]) |=> status_code == ST_FSTBY ##0
		forced_standby_req)
		else $error("forced standby status code wrong");

	reserved_none_a: assert property (
		(wr_dout && $stable(nc_mode)) |=> $stable(standby_req) &&
		$stable(forced_standby_req) && $stable(regulator_on) &&
		$stable(status_code))
		else $error("byte 1 write touched byte 0 functions");

	isolate_code_a: assert property (
		(!standby_req && !forced_standby_req && isolated) |->
		status_code == ST_ISOLATE)
		else $error("isolation status code wrong");

	// drive follows the stored bits one edge after the switch was sampled
	nc_steady_a: assert property (
		($past(nc_mode) && !$past(rst)) |->
		(regulator_on == nc_supply) && (valve_drive_on == nc_supply))
		else $error("nc drive does not follow stored bit");

	no_steady_a: assert property (
		(!$past(nc_mode) && !$past(rst)) |->
		(regulator_on == no_supply) && (valve_drive_on == !no_supply))
		else $error("no drive does not follow stored bit");

endmodule // apod_top

`default_nettype wire

// ### common/apod_pkg.sv
`default_nettype none

package apod_pkg;

	// ----------------------------------------------------------------
	// output image layout
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL     = 5'h00;
	localparam logic [4:0] OFS_DOUT     = 5'h01;
	localparam logic [4:0] OFS_PD_FIRST = 5'h02;
	localparam logic [4:0] OFS_PD_LAST  = 5'h11;
	localparam int unsigned PD_BYTES = 16;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_STBY   = 0;
	localparam int unsigned BIT_FSTBY  = 1;
	localparam int unsigned BIT_ISO_NC = 2;
	localparam int unsigned BIT_ISO_NO = 3;
	localparam int unsigned BIT_DOUT   = 6;

	// ----------------------------------------------------------------
	// reset values and status codes
	// ----------------------------------------------------------------
	localparam logic [7:0] BYTE_RST   = 8'h00;
	localparam logic [7:0] ST_OPER    = 8'h01;
	localparam logic [7:0] ST_STBY    = 8'h03;
	localparam logic [7:0] ST_FSTBY   = 8'h23;
	localparam logic [7:0] ST_ISOLATE = 8'h24;

endpackage

`default_nettype wire

// ### common/apod_wr_if.sv
`timescale 1ns/1ps
`default_nettype none

// byte write strobe shared by the decoder and its process data bytes
interface apod_wr_if;
	logic       wr_en;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;

	modport src (output wr_en, output wr_addr, output wr_data);
	modport dst (input wr_en, input wr_addr, input wr_data);
endinterface

`default_nettype wire

// ### rtl/apod_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none

module apod_byte_reg
#(
	parameter logic [4:0] BYTE_OFS = 5'h02
)
(
	input  wire logic     sys_clk,
	input  wire logic     rst,
	apod_wr_if.dst        wr,
	output var  logic [7:0] q
);
	import apod_pkg::*;

	typedef struct packed
	{
		logic [7:0] data;
	} apod_byte_st_t;

	apod_byte_st_t st_reg;
	apod_byte_st_t st_next;

	// ----------------------------------------------------------------
	// pass-through byte
	// ----------------------------------------------------------------
	// byte copied untouched; no decode on process data
	always_comb
	begin
		st_next = st_reg;
		if (wr.wr_en && wr.wr_addr == BYTE_OFS)
		begin
			st_next.data = wr.wr_data;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st_reg <= '{data: BYTE_RST};
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.data;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	pd_byte_pass_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		(wr.wr_en && wr.wr_addr == BYTE_OFS) |=> (q == $past(wr.wr_data)))
		else $error("process data byte not forwarded");

	pd_byte_hold_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		!(wr.wr_en && wr.wr_addr == BYTE_OFS) |=> $stable(q))
		else $error("process data byte changed without write");

endmodule // apod_byte_reg

`default_nettype wire

// ### sim/apod_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// fieldbus controller writing the cyclic output image
// ----------------------------------------------------------------
module apod_ctrl_model
(
	input  wire logic       sys_clk,
	output var  logic       wr_en,
	output var  logic [4:0] wr_addr,
	output var  logic [7:0] wr_data
);
	import apod_pkg::*;

	// quiet bus at time zero
	initial
	begin
		wr_en = 1'b0;
		wr_addr = 5'h1f;
		wr_data = 8'h00;
	end

	// one byte per strobe; call at a falling edge, back to back allowed
	task automatic put(input logic [4:0] a, input logic [7:0] d);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(negedge sys_clk);
	endtask

	// released bus shows inverted values so stale bytes never look valid
	task automatic idle();
		wr_en <= 1'b0;
		wr_addr <= ~wr_addr;
		wr_data <= ~wr_data;
	endtask
endmodule // apod_ctrl_model

`default_nettype wire

// ### sim/test_air_process_output_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module test_air_process_output_decoder;
	import apod_pkg::*;

	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	logic         nc_mode = 1'b1;
	logic         wr_en;
	logic [4:0]   wr_addr;
	logic [7:0]   wr_data;
	logic         standby_req;
	logic         forced_standby_req;
	logic         regulator_on;
	logic         valve_drive_on;
	logic         port4_dout;
	logic [127:0] iolink_pd;
	logic [7:0]   status_code;
	int           err_total = 0;
	int           n_tests = 0;
	int           img [18];

	always #10 sys_clk = ~sys_clk;

	apod_ctrl_model u_apod_ctrl_model (.sys_clk(sys_clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data));

	apod_top u_apod_top (.sys_clk(sys_clk), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .nc_mode(nc_mode), .standby_req(standby_req),
		.forced_standby_req(forced_standby_req), .regulator_on(regulator_on),
		.valve_drive_on(valve_drive_on), .port4_dout(port4_dout), .iolink_pd(iolink_pd),
		.status_code(status_code));

	// ----------------------------------------------------------------
	// reference model of the decode
	// ----------------------------------------------------------------
	function automatic logic [140:0] expect_out();
		logic r;
		logic v;
		logic [7:0] st;
		logic [127:0] pd;
		r = nc_mode ? img[0][2] : !img[0][3];
		v = nc_mode ? img[0][2] : img[0][3];
		st = img[0][1] ? 8'h23 : img[0][0] ? 8'h03 : !r ? 8'h24 : 8'h01;
		for (int k = 0; k < 16; k++)
			pd[8*k +: 8] = img[k+2][7:0];
		return {img[0][0] == 1, img[0][1] == 1, r, v, img[1][6] == 1, st, pd};
	endfunction

	// compares every output against the model
	task automatic check();
		logic [140:0] got;
		logic [140:0] exp;
		got = {standby_req, forced_standby_req, regulator_on, valve_drive_on, port4_dout,
			status_code, iolink_pd};
		exp = expect_out();
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// single write, then one spare edge; the drive decode already lands on the write edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_apod_ctrl_model.put(a, d);
		if (a < 5'd18)
			img[a] = d;
		u_apod_ctrl_model.idle();
		@(negedge sys_clk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(38));
		foreach (img[i])
			img[i] = 0;
		repeat (20) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		@(negedge sys_clk);
		check();
		// every isolation/standby code in both switch settings, noisy reserved nibble
		for (int m = 0; m < 2; m++)
		begin
			nc_mode = m[0];
			@(negedge sys_clk);
			@(negedge sys_clk);
			check();
			for (int b = 0; b < 16; b++)
			begin
				wr(5'h00, {4'($urandom), 4'(b)});
				check();
				check();
			end
		end
		// walking one and walking zero over the digital output byte
		for (int i = 0; i < 8; i++)
		begin
			wr(5'h01, 8'(1 << i));
			check();
			wr(5'h01, ~8'(1 << i));
			check();
		end
		// process data back to back, then unmapped bytes that must change nothing
		for (int k = 2; k < 18; k++)
		begin
			img[k] = 8'($urandom);
			u_apod_ctrl_model.put(5'(k), 8'(img[k]));
		end
		for (int a = 18; a < 32; a++)
			u_apod_ctrl_model.put(5'(a), 8'($urandom));
		u_apod_ctrl_model.idle();
		@(negedge sys_clk);
		check();
		// second reset in mid-run clears the image
		rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		foreach (img[i])
			img[i] = 0;
		@(negedge sys_clk);
		@(negedge sys_clk);
		check();
		stop_test();
	end
endmodule // test_air_process_output_decoder

`default_nettype wire
